/* File: rtl/vagsr_regs.sv */
// vendor alert, gpio status and toggle timing register bank behind apb
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module vagsr_regs #(
	parameter int TICK_CYCLES = vagsr_pkg::TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pin1_in,
	input  wire logic        pin2_in,
	input  wire logic        discharge_done,
	input  wire logic        supply_detect_change,
	input  wire logic        overtemp_event,
	input  wire logic        swap_sent,
	input  wire logic        swap_request_rx,
	input  wire logic        swap_detected,
	output logic             pin1_input_buffer_on,
	output logic             pin2_input_buffer_on,
	output logic [1:0]       dual_role_toggle_timing,
	output logic             advertise_source,
	output logic             alert_irq,
	output logic             irq
);
	logic [1:0]  gp_input_levels_r;
	logic [1:0]  pin_prev_r;
	logic [1:0]  gp_cfg_r;
	logic [1:0]  toggle_r;
	logic [6:0]  flags_r;
	logic [6:0]  flags_nxt;
	logic [6:0]  enables_r;
	logic [1:0]  stat_r;
	logic [1:0]  stat_nxt;
	logic [1:0]  irq_mask_r;
	logic        soft_rst_r;
	logic        tick;
	logic        adv_src;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic        hit;
	logic [6:0]  events;
	logic [7:0]  rdata8;
	logic [1:0]  pin_now;

	function automatic logic at(input logic [7:0] i, input logic [7:0] want);
		at = (i == want);
	endfunction

	assign idx     = paddr[9:2];
	assign wr      = psel && penable && pwrite && pready;
	assign rd      = psel && penable && !pwrite && pready;
	assign pin_now = {pin2_in, pin1_in};

	always_comb begin
		hit = at(idx, vagsr_pkg::IDX_GP_INPUT_LEVELS) || at(idx, vagsr_pkg::IDX_DUAL_ROLE_TOGGLE) ||
		      at(idx, vagsr_pkg::IDX_SOURCE_SWAP_CTRL) || at(idx, vagsr_pkg::IDX_SINK_SWAP_CTRL) ||
		      at(idx, vagsr_pkg::IDX_VENDOR_ALERT_FLAGS) || at(idx, vagsr_pkg::IDX_VENDOR_ALERT_ENA) ||
		      at(idx, vagsr_pkg::IDX_GP_CFG) || at(idx, vagsr_pkg::IDX_SOFT_RESET) ||
		      at(idx, vagsr_pkg::IDX_ALERT_STATUS) || at(idx, vagsr_pkg::IDX_ALERT_IRQ_MASK) ||
		      at(idx, vagsr_pkg::IDX_TOGGLE_STATE);
		hit = hit && (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	end

	vagsr_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (soft_rst_r),
		.tick    (tick)
	);

	vagsr_toggle u_toggle (
		.pclk             (pclk),
		.presetn          (presetn),
		.clr              (soft_rst_r),
		.tick             (tick),
		.timing_sel       (toggle_r),
		.advertise_source (adv_src)
	);

	// one wait state: pready is low in the first access cycle, high in the second, then drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	// software reset pulse, cleared the next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr && at(idx, vagsr_pkg::IDX_SOFT_RESET) && pstrb[0] &&
			              pwdata[vagsr_pkg::POS_SOFTWARE_RESET];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_cfg_r <= vagsr_pkg::RST_GP_CFG[1:0];
		end else if (soft_rst_r) begin
			gp_cfg_r <= vagsr_pkg::RST_GP_CFG[1:0];
		end else if (wr && pstrb[0] && at(idx, vagsr_pkg::IDX_GP_CFG)) begin
			gp_cfg_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_r <= vagsr_pkg::RST_DUAL_ROLE_TOGGLE[1:0];
		end else if (soft_rst_r) begin
			toggle_r <= vagsr_pkg::RST_DUAL_ROLE_TOGGLE[1:0];
		end else if (wr && pstrb[0] && at(idx, vagsr_pkg::IDX_DUAL_ROLE_TOGGLE)) begin
			toggle_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_r <= vagsr_pkg::RST_VENDOR_ALERT_ENA[6:0];
		end else if (soft_rst_r) begin
			enables_r <= vagsr_pkg::RST_VENDOR_ALERT_ENA[6:0];
		end else if (wr && pstrb[0] && at(idx, vagsr_pkg::IDX_VENDOR_ALERT_ENA)) begin
			enables_r <= pwdata[6:0];
		end
	end

	// pin levels held at zero while the input buffer is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_input_levels_r <= vagsr_pkg::RST_GP_INPUT_LEVELS[1:0];
			pin_prev_r        <= 2'b00;
		end else if (soft_rst_r) begin
			gp_input_levels_r <= vagsr_pkg::RST_GP_INPUT_LEVELS[1:0];
			pin_prev_r        <= 2'b00;
		end else begin
			gp_input_levels_r[vagsr_pkg::POS_PIN1_LEVEL] <= gp_cfg_r[vagsr_pkg::POS_PIN1_BUF_ON] &&
			                                                pin1_in;
			gp_input_levels_r[vagsr_pkg::POS_PIN2_LEVEL] <= gp_cfg_r[vagsr_pkg::POS_PIN2_BUF_ON] &&
			                                                pin2_in;
			pin_prev_r <= pin_now & gp_cfg_r;
		end
	end

	always_comb begin
		events = 7'h00;
		events[vagsr_pkg::POS_ALERT_DISCHARGE_DONE] = discharge_done;
		events[vagsr_pkg::POS_ALERT_PIN2_CHANGE]    = gp_cfg_r[1] && (pin_now[1] != pin_prev_r[1]);
		events[vagsr_pkg::POS_ALERT_PIN1_CHANGE]    = gp_cfg_r[0] && (pin_now[0] != pin_prev_r[0]);
		events[vagsr_pkg::POS_ALERT_SUPPLY_DETECT]  = supply_detect_change;
		events[vagsr_pkg::POS_ALERT_OVERTEMP]       = overtemp_event;
		events[vagsr_pkg::POS_ALERT_SWAP_TX]        = swap_sent;
		events[vagsr_pkg::POS_ALERT_SWAP_RX]        = swap_request_rx;
	end

	// write one clears; a new event in the same cycle wins
	always_comb begin
		flags_nxt = flags_r;
		if (wr && pstrb[0] && at(idx, vagsr_pkg::IDX_VENDOR_ALERT_FLAGS)) begin
			flags_nxt = flags_r & ~pwdata[6:0];
		end
		flags_nxt = (flags_nxt | events) & vagsr_pkg::ALERT_DEFINED;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= vagsr_pkg::RST_VENDOR_ALERT_FLAGS[6:0];
		end else if (soft_rst_r) begin
			flags_r <= vagsr_pkg::RST_VENDOR_ALERT_FLAGS[6:0];
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// block status: sticky, cleared by reading it; set wins
	always_comb begin
		stat_nxt = stat_r;
		if (rd && at(idx, vagsr_pkg::IDX_ALERT_STATUS)) begin
			stat_nxt = 2'b00;
		end
		if (|(flags_nxt & enables_r & ~flags_r)) begin
			stat_nxt[vagsr_pkg::POS_STAT_VENDOR_ALERT] = 1'b1;
		end
		if (soft_rst_r) begin
			stat_nxt[vagsr_pkg::POS_STAT_SOFT_RESET_DONE] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r     <= 2'b00;
			irq_mask_r <= vagsr_pkg::RST_ALERT_IRQ_MASK;
		end else begin
			stat_r <= stat_nxt;
			if (soft_rst_r) begin
				irq_mask_r <= vagsr_pkg::RST_ALERT_IRQ_MASK;
			end else if (wr && pstrb[0] && at(idx, vagsr_pkg::IDX_ALERT_IRQ_MASK)) begin
				irq_mask_r <= pwdata[1:0];
			end
		end
	end

	always_comb begin
		case (idx)
			vagsr_pkg::IDX_GP_INPUT_LEVELS:    rdata8 = {6'h00, gp_input_levels_r};
			vagsr_pkg::IDX_DUAL_ROLE_TOGGLE:   rdata8 = {6'h00, toggle_r};
			vagsr_pkg::IDX_SOURCE_SWAP_CTRL:   rdata8 = vagsr_pkg::RST_SWAP_CTRL;
			vagsr_pkg::IDX_SINK_SWAP_CTRL:     rdata8 = vagsr_pkg::RST_SWAP_CTRL;
			vagsr_pkg::IDX_VENDOR_ALERT_FLAGS: rdata8 = {1'b0, flags_r};
			vagsr_pkg::IDX_VENDOR_ALERT_ENA:   rdata8 = {1'b0, enables_r};
			vagsr_pkg::IDX_GP_CFG:             rdata8 = {6'h00, gp_cfg_r};
			vagsr_pkg::IDX_SOFT_RESET:         rdata8 = 8'h00;
			vagsr_pkg::IDX_ALERT_STATUS:       rdata8 = {6'h00, stat_r};
			vagsr_pkg::IDX_ALERT_IRQ_MASK:     rdata8 = {6'h00, irq_mask_r};
			vagsr_pkg::IDX_TOGGLE_STATE:       rdata8 = {7'h00, adv_src};
			default:                           rdata8 = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata8};
			pslverr <= !hit;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// all outputs registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin1_input_buffer_on    <= 1'b0;
			pin2_input_buffer_on    <= 1'b0;
			dual_role_toggle_timing <= 2'b00;
			advertise_source        <= 1'b1;
			alert_irq               <= 1'b0;
			irq                     <= 1'b0;
		end else begin
			pin1_input_buffer_on    <= gp_cfg_r[vagsr_pkg::POS_PIN1_BUF_ON];
			pin2_input_buffer_on    <= gp_cfg_r[vagsr_pkg::POS_PIN2_BUF_ON];
			dual_role_toggle_timing <= toggle_r;
			advertise_source        <= adv_src;
			alert_irq               <= |(flags_r & enables_r);
			irq                     <= |(stat_r & irq_mask_r);
		end
	end

	// sink swap register has no storage: detection has nothing to clear
	logic unused_ok;
	assign unused_ok = swap_detected & |pwdata[31:8] & |pstrb[3:1];
endmodule

/* File: rtl/vagsr_pkg.sv */
// package: register map, field positions, reset values and timing for the vendor alert / gpio status bank
package vagsr_pkg;

	// register offsets: printed offsets are not all multiples of four, so they are indices
	localparam logic [7:0] IDX_GP_INPUT_LEVELS     = 8'ha6;
	localparam logic [7:0] IDX_DUAL_ROLE_TOGGLE    = 8'ha7;
	localparam logic [7:0] IDX_SOURCE_SWAP_CTRL    = 8'hb1;
	localparam logic [7:0] IDX_SINK_SWAP_CTRL      = 8'hb2;
	localparam logic [7:0] IDX_VENDOR_ALERT_FLAGS  = 8'hb3;
	localparam logic [7:0] IDX_VENDOR_ALERT_ENA    = 8'hb4;
	// own registers
	localparam logic [7:0] IDX_GP_CFG              = 8'hc0;
	localparam logic [7:0] IDX_SOFT_RESET          = 8'hc1;
	localparam logic [7:0] IDX_ALERT_STATUS        = 8'hc2;
	localparam logic [7:0] IDX_ALERT_IRQ_MASK      = 8'hc3;
	localparam logic [7:0] IDX_TOGGLE_STATE        = 8'hc4;

	// reset values
	localparam logic [7:0] RST_GP_INPUT_LEVELS     = 8'h00;
	localparam logic [7:0] RST_DUAL_ROLE_TOGGLE    = 8'h00;
	localparam logic [7:0] RST_SWAP_CTRL           = 8'h00;
	localparam logic [7:0] RST_VENDOR_ALERT_FLAGS  = 8'h00;
	localparam logic [7:0] RST_VENDOR_ALERT_ENA    = 8'h7f;
	localparam logic [7:0] RST_GP_CFG              = 8'h00;
	localparam logic [1:0] RST_ALERT_IRQ_MASK      = 2'h0;

	// field positions
	localparam int POS_PIN1_LEVEL                  = 0;
	localparam int POS_PIN2_LEVEL                  = 1;
	localparam int POS_PIN1_BUF_ON                 = 0;
	localparam int POS_PIN2_BUF_ON                 = 1;
	localparam int POS_SOFTWARE_RESET              = 0;
	localparam int POS_ALERT_SWAP_RX               = 0;
	localparam int POS_ALERT_SWAP_TX               = 1;
	localparam int POS_ALERT_OVERTEMP              = 2;
	localparam int POS_ALERT_SUPPLY_DETECT         = 3;
	localparam int POS_ALERT_PIN1_CHANGE           = 4;
	localparam int POS_ALERT_PIN2_CHANGE           = 5;
	localparam int POS_ALERT_DISCHARGE_DONE        = 6;
	localparam int POS_STAT_VENDOR_ALERT           = 0;
	localparam int POS_STAT_SOFT_RESET_DONE        = 1;
	localparam int ALERT_BITS                      = 7;
	localparam logic [6:0] ALERT_DEFINED           = 7'h7f;

	// toggle dwell minimums in ms, per setting 00b..11b
	localparam int SRC_DWELL_MS_0                  = 15;
	localparam int SRC_DWELL_MS_1                  = 20;
	localparam int SRC_DWELL_MS_2                  = 25;
	localparam int SRC_DWELL_MS_3                  = 30;
	localparam int SNK_DWELL_MS_0                  = 35;
	localparam int SNK_DWELL_MS_1                  = 30;
	localparam int SNK_DWELL_MS_2                  = 25;
	localparam int SNK_DWELL_MS_3                  = 20;
	localparam int CLK_HZ                          = 20000000;
	localparam int TICK_US                         = 1000;
	// cycles per 1 ms tick, rounded up
	localparam int TICK_CYCLES                     = (CLK_HZ / 1000 * TICK_US + 999) / 1000;

	typedef enum logic [1:0] {
		VAGSR_TOG_SRC  = 2'b00,
		VAGSR_TOG_SNK  = 2'b01
	} vagsr_tog_state_t;

endpackage

/* File: rtl/vagsr_tick.sv */
// divider producing a one-cycle tick enable every tick_cycles clocks
`timescale 1ns/1ps
module vagsr_tick #(
	parameter int TICK_CYCLES = vagsr_pkg::TICK_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clr,
	output logic      tick
);
	localparam int W = $clog2(TICK_CYCLES + 1);
	logic [W-1:0] cnt_r;

	initial begin
		if (TICK_CYCLES < 1) $error("tick_cycles must be at least one");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (clr) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == W'(TICK_CYCLES - 1)) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

/* File: rtl/vagsr_toggle.sv */
// dual role toggle timer: alternates source and sink dwell per the timing setting
`timescale 1ns/1ps
module vagsr_toggle (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clr,
	input  wire logic       tick,
	input  wire logic [1:0] timing_sel,
	output logic            advertise_source
);
	logic [6:0]             ms_r;
	vagsr_pkg::vagsr_tog_state_t st_r;

	function automatic logic [6:0] dwell_ms(input logic [1:0] sel, input logic src);
		case (sel)
			2'b00:   dwell_ms = src ? 7'(vagsr_pkg::SRC_DWELL_MS_0) : 7'(vagsr_pkg::SNK_DWELL_MS_0);
			2'b01:   dwell_ms = src ? 7'(vagsr_pkg::SRC_DWELL_MS_1) : 7'(vagsr_pkg::SNK_DWELL_MS_1);
			2'b10:   dwell_ms = src ? 7'(vagsr_pkg::SRC_DWELL_MS_2) : 7'(vagsr_pkg::SNK_DWELL_MS_2);
			default: dwell_ms = src ? 7'(vagsr_pkg::SRC_DWELL_MS_3) : 7'(vagsr_pkg::SNK_DWELL_MS_3);
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= vagsr_pkg::VAGSR_TOG_SRC;
			ms_r <= '0;
		end else if (clr) begin
			st_r <= vagsr_pkg::VAGSR_TOG_SRC;
			ms_r <= '0;
		end else if (tick) begin
			case (st_r)
				vagsr_pkg::VAGSR_TOG_SRC: begin
					if (ms_r + 7'd1 >= dwell_ms(timing_sel, 1'b1)) begin
						st_r <= vagsr_pkg::VAGSR_TOG_SNK;
						ms_r <= '0;
					end else begin
						ms_r <= ms_r + 7'd1;
					end
				end
				vagsr_pkg::VAGSR_TOG_SNK: begin
					if (ms_r + 7'd1 >= dwell_ms(timing_sel, 1'b0)) begin
						st_r <= vagsr_pkg::VAGSR_TOG_SRC;
						ms_r <= '0;
					end else begin
						ms_r <= ms_r + 7'd1;
					end
				end
				default: begin
					st_r <= vagsr_pkg::VAGSR_TOG_SRC;
					ms_r <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			advertise_source <= 1'b1;
		end else begin
			advertise_source <= (st_r == vagsr_pkg::VAGSR_TOG_SRC);
		end
	end
endmodule

/* File: sim/vagsr_regs_checker.sv */
// checker: apb timing and register bank properties of vagsr_regs
`timescale 1ns/1ps
module vagsr_regs_checker #(
	parameter int TICK_CYCLES = vagsr_pkg::TICK_CYCLES
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pin1_in,
	input wire logic        pin2_in,
	input wire logic        discharge_done,
	input wire logic        supply_detect_change,
	input wire logic        overtemp_event,
	input wire logic        swap_sent,
	input wire logic        swap_request_rx,
	input wire logic        swap_detected,
	input wire logic        pin1_input_buffer_on,
	input wire logic        pin2_input_buffer_on,
	input wire logic [1:0]  dual_role_toggle_timing,
	input wire logic        advertise_source,
	input wire logic        alert_irq,
	input wire logic        irq
);
	wire logic [7:0] idx   = paddr[9:2];
	wire logic       rd_ok = pready && !pwrite;
	wire logic       wr_ok = pready && pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_pins_steady;
		pin1_input_buffer_on && pin2_input_buffer_on && $stable(pin1_in) && $stable(pin2_in);
	endsequence
	a_ready_wait: assert property (s_wait |=> pready) else $error("no answer after wait state");
	a_ready_access: assert property (pready |-> psel && penable) else $error("answer outside access");
	a_ready_pulse: assert property (pready |=> !pready) else $error("answer longer than one cycle");
	a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned not refused");
	a_flags_bit7: assert property (rd_ok && idx == 8'hb3 |-> prdata[31:7] == 25'h0)
		else $error("alert flag read has upper bits set");
	a_swap_zero: assert property (rd_ok && (idx == 8'hb1 || idx == 8'hb2) |-> prdata == 32'h0)
		else $error("swap register not zero");
	a_pin_levels: assert property (s_pins_steady [*4] ##0 (rd_ok && idx == 8'ha6)
		|-> prdata[1:0] == {pin2_in, pin1_in}) else $error("input levels wrong");
	a_irq_release: assert property ($fell(alert_irq)
		|-> $past(wr_ok, 1) || $past(wr_ok, 2) || $past(wr_ok, 3)) else $error("alert irq fell without write");
	a_toggle_hold: assert property ($changed(dual_role_toggle_timing)
		|-> $past(wr_ok, 1) || $past(wr_ok, 2) || $past(wr_ok, 3)) else $error("toggle field changed alone");
endmodule
bind vagsr_regs vagsr_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin1_in(pin1_in), .pin2_in(pin2_in), .discharge_done(discharge_done),
	.supply_detect_change(supply_detect_change), .overtemp_event(overtemp_event), .swap_sent(swap_sent),
	.swap_request_rx(swap_request_rx), .swap_detected(swap_detected), .pin1_input_buffer_on(pin1_input_buffer_on),
	.pin2_input_buffer_on(pin2_input_buffer_on), .dual_role_toggle_timing(dual_role_toggle_timing),
	.advertise_source(advertise_source), .alert_irq(alert_irq), .irq(irq));

/* File: sim/vagsr_regs_test.sv */
// self-checking bench for the vendor alert and gpio status register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module vagsr_regs_test;
	localparam int TC = 4;
	typedef struct packed {logic w; logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic err;} vagsr_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'hf;
	logic [6:0] ev = 7'h00;
	logic pin1_in = 1'b0, pin2_in = 1'b0, swap_detected = 1'b0;
	logic pready, pslverr, b1_on, b2_on, adv, alert_irq, irq, rerr;
	logic [1:0] tog;
	int n_fail = 0, compares = 0, nh, nl;
	int bits [5] = '{0, 1, 2, 3, 6};
	int src [4] = '{15, 20, 25, 30};
	int snk [4] = '{35, 30, 25, 20};
	logic [7:0] sr_idx [5] = '{8'ha7, 8'hb3, 8'hb4, 8'hc0, 8'hc1};
	logic [7:0] sr_val [5] = '{8'h00, 8'h00, 8'h7f, 8'h00, 8'h00};
	vagsr_row_t rows [18] = '{{1'b0, 8'ha6, 8'h00, 8'h00, 1'b0}, {1'b0, 8'ha7, 8'h00, 8'h00, 1'b0},
		{1'b0, 8'hb1, 8'h00, 8'h00, 1'b0}, {1'b0, 8'hb2, 8'h00, 8'h00, 1'b0}, {1'b0, 8'hb3, 8'h00, 8'h00, 1'b0},
		{1'b0, 8'hb4, 8'h00, 8'h7f, 1'b0}, {1'b1, 8'ha7, 8'hff, 8'h00, 1'b0}, {1'b0, 8'ha7, 8'h00, 8'h03, 1'b0},
		{1'b1, 8'hb1, 8'hff, 8'h00, 1'b0}, {1'b0, 8'hb1, 8'h00, 8'h00, 1'b0}, {1'b1, 8'hb2, 8'hff, 8'h00, 1'b0},
		{1'b0, 8'hb2, 8'h00, 8'h00, 1'b0}, {1'b1, 8'hb4, 8'hff, 8'h00, 1'b0}, {1'b0, 8'hb4, 8'h00, 8'h7f, 1'b0},
		{1'b1, 8'ha6, 8'hff, 8'h00, 1'b0}, {1'b0, 8'ha6, 8'h00, 8'h00, 1'b0}, {1'b0, 8'h55, 8'h00, 8'h00, 1'b1},
		{1'b1, 8'h55, 8'hff, 8'h00, 1'b1}};
	vagsr_regs #(.TICK_CYCLES(TC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin1_in(pin1_in), .pin2_in(pin2_in), .discharge_done(ev[6]),
		.supply_detect_change(ev[3]), .overtemp_event(ev[2]), .swap_sent(ev[1]), .swap_request_rx(ev[0]),
		.swap_detected(swap_detected), .pin1_input_buffer_on(b1_on), .pin2_input_buffer_on(b2_on),
		.dual_role_toggle_timing(tog), .advertise_source(adv), .alert_irq(alert_irq), .irq(irq));
	always #25 pclk = ~pclk;
	task automatic final_report;
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// answer sampled and taken at the rising edge where pready is high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		if (n >= 20) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rg(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		apb(w, {2'b00, idx, 2'b00}, wd);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		rg(1'b0, idx, 8'h00);
		`CHK(rdat, {24'h0, e})
	endtask
	task automatic pulse(input int b);
		@(posedge pclk);
		ev[b] <= 1'b1;
		@(posedge pclk);
		ev[b] <= 1'b0;
		repeat (3) @(negedge pclk);
	endtask
	task automatic pins(input logic p1, input logic p2);
		@(posedge pclk);
		pin1_in <= p1;
		pin2_in <= p2;
		repeat (4) @(negedge pclk);
	endtask
	task automatic cnt(input logic lv, output int n);
		n = 0;
		while (adv === lv && n < 1000) begin
			@(negedge pclk);
			n++;
		end
	endtask
	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		final_report();
	end
	initial begin
		int b;
		logic [7:0] m;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK({adv, alert_irq, irq, b1_on, b2_on, tog}, 7'b1000000)
		foreach (rows[i]) begin
			rg(rows[i].w, rows[i].idx, rows[i].wd);
			`CHK(rerr, rows[i].err)
			if (!rows[i].w) `CHK(rdat, {24'h0, rows[i].rd})
		end
		foreach (bits[i]) begin
			b = bits[i];
			m = 8'h01 << b;
			rg(1'b1, 8'hb4, 8'h7f & ~m);
			pulse(b);
			`CHK(alert_irq, 1'b0)
			rdc(8'hb3, m);
			rg(1'b1, 8'hb3, ~m);
			rdc(8'hb3, m);
			rg(1'b1, 8'hb4, 8'h7f);
			repeat (2) @(negedge pclk);
			`CHK(alert_irq, 1'b1)
			rg(1'b1, 8'hb3, m);
			repeat (2) @(negedge pclk);
			`CHK(alert_irq, 1'b0)
		end
		rg(1'b0, 8'hc2, 8'h00);
		rg(1'b1, 8'hc3, 8'h00);
		pulse(0);
		`CHK(irq, 1'b0)
		rg(1'b1, 8'hc3, 8'h01);
		repeat (2) @(negedge pclk);
		`CHK(irq, 1'b1)
		rg(1'b0, 8'hc2, 8'h00);
		`CHK(rdat[0], 1'b1)
		repeat (2) @(negedge pclk);
		`CHK(irq, 1'b0)
		rg(1'b1, 8'hb3, 8'h01);
		rg(1'b1, 8'hc0, 8'h03);
		repeat (2) @(negedge pclk);
		`CHK({b1_on, b2_on}, 2'b11)
		pins(1'b1, 1'b0);
		rdc(8'ha6, 8'h01);
		rdc(8'hb3, 8'h10);
		pins(1'b1, 1'b1);
		rdc(8'ha6, 8'h03);
		rdc(8'hb3, 8'h30);
		rg(1'b1, 8'hb3, 8'h30);
		rg(1'b1, 8'hc0, 8'h00);
		pins(1'b0, 1'b0);
		rdc(8'hb3, 8'h00);
		foreach (src[s]) begin
			rg(1'b1, 8'ha7, s[7:0]);
			repeat (2) @(negedge pclk);
			`CHK(tog, s[1:0])
			cnt(1'b1, nh);
			cnt(1'b0, nl);
			cnt(1'b1, nh);
			cnt(1'b0, nl);
			`CHK(nh >= src[s] * TC && nh <= 2 * src[s] * TC, 1'b1)
			`CHK(nl >= snk[s] * TC && nl <= 2 * snk[s] * TC, 1'b1)
		end
		rg(1'b1, 8'hb4, 8'h00);
		rg(1'b1, 8'hc0, 8'h03);
		pulse(2);
		rg(1'b1, 8'hc1, 8'h01);
		repeat (2) @(negedge pclk);
		foreach (sr_idx[i]) rdc(sr_idx[i], sr_val[i]);
		`CHK({b1_on, b2_on, tog, alert_irq}, 5'b00000)
		pstrb <= 4'h0;
		rg(1'b1, 8'ha7, 8'h02);
		pstrb <= 4'hf;
		rdc(8'ha7, 8'h00);
		apb(1'b0, 12'h29d, 8'h00);
		`CHK({rerr, rdat}, 33'h100000000)
		final_report();
	end
endmodule
